// ==== core/abd_map.svh ====
// register offsets, field positions, reset values and counts of the
// auto-baud block; assumes a 32-bit word-aligned register map
`ifndef ABD_MAP_SVH
`define ABD_MAP_SVH
`define ABD_OFF_CTL    8'h00
`define ABD_OFF_LOW    8'h04
`define ABD_OFF_HIGH   8'h08
`define ABD_OFF_RXBUF  8'h0c
`define ABD_OFF_STS    8'h10
`define ABD_OFF_MASK   8'h14
`define ABD_CTL_START  0
`define ABD_CTL_WIDE   1
`define ABD_CTL_HS     2
`define ABD_CTL_WOB    3
`define ABD_CTL_BUSY   4
`define ABD_EV_DONE    0
`define ABD_EV_OVF     1
`define ABD_EV_BRK     2
`define ABD_EV_W       3
`define ABD_CNT_RST    16'h0000
`define ABD_CNT_FIRST  16'h0001
`define ABD_CNT_ONE    16'h0001
`define ABD_CNT_MAX    16'hffff
`define ABD_EDGES_LAST 3'h5
`define ABD_EDGE_ONE   3'h1
`define ABD_DIV512_LAST 9'h1ff
`define ABD_DIV128_LAST 9'h07f
`define ABD_DIV32_LAST  9'h01f
`define ABD_PRE_ONE    9'h001
`endif

// ==== core/abd_pkg.sv ====
// types shared by the auto-baud block; constants live in abd_map.svh
package abd_pkg;
  typedef enum logic [2:0] {
    S_IDLE,
    S_BRK_FALL,
    S_BRK_RISE,
    S_START,
    S_FIRST,
    S_COUNT
  } abd_state_t;
  typedef logic [15:0] rate_count_t;
endpackage

// ==== core/uart_auto_baud_detect.sv ====
// auto-baud measurement of a 55h sync character behind a Wishbone slave
// assumes one 40 MHz clock and a receive pin from outside this domain
//
// Function
// - writing one to the start bit launches the measurement of the line
// - the normal receiver is held idle while the measurement runs
// - count pair starts at the first rising edge after the start bit
// - at the fifth edge keep count, clear start bit, raise receive flag
// - low and high rate registers form one 16-bit counter during measuring
// - counter advances at one eighth of the selected base clock rate
// - counter clock: 00 gives /512, 01 and 10 give /128, 11 gives /32
// - counter starts at one; software subtracts one from the result
// - with wake-on-break set, the character after the break is measured
//
// Added by the designer: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "abd_map.svh"

module uart_auto_baud_detect
  import abd_pkg::*;
(
  input  wire logic        MCLK_IN,     // 40 MHz clock
  input  wire logic        RESET_IN,    // async reset, active high
  input  wire logic        WB_CYC_IN,   // bus cycle
  input  wire logic        WB_STB_IN,   // bus strobe
  input  wire logic        WB_WE_IN,    // write enable
  input  wire logic [7:0]  WB_ADR_IN,   // byte address
  input  wire logic [3:0]  WB_SEL_IN,   // byte enables
  input  wire logic [31:0] WB_DAT_IN,   // write data
  output logic      [31:0] WB_DAT_OUT,  // read data
  output logic             WB_ACK_OUT,  // acknowledge
  input  wire logic        RX_IN,       // receive pin
  output logic             IRQ_OUT,     // level interrupt
  output logic             RXIF_OUT,    // receive interrupt flag
  output logic             RX_HOLD_OUT  // holds receiver idle
);

  function automatic logic [8:0] div_last(input logic wide,
                                          input logic hs);
    logic [8:0] d;
    d = `ABD_DIV128_LAST;
    if (!wide && !hs) begin
      d = `ABD_DIV512_LAST;
    end else if (wide && hs) begin
      d = `ABD_DIV32_LAST;
    end
    return d;
  endfunction

  logic                  rx_m_r;
  logic                  rx_s_r;
  logic                  rx_d_r;
  logic                  rise;
  logic                  fall;
  logic                  tick;
  abd_state_t            state_r;
  abd_state_t            state_nxt;
  rate_count_t           cnt_r;
  rate_count_t           cnt_nxt;
  logic [2:0]            edges_r;
  logic [2:0]            edges_nxt;
  logic [8:0]            pre_r;
  logic [8:0]            pre_nxt;
  logic                  start_r;
  logic                  start_nxt;
  logic                  wide_r;
  logic                  wide_nxt;
  logic                  hs_r;
  logic                  hs_nxt;
  logic                  wob_r;
  logic                  wob_nxt;
  logic [`ABD_EV_W-1:0]  sts_r;
  logic [`ABD_EV_W-1:0]  sts_nxt;
  logic [`ABD_EV_W-1:0]  sts_set;
  logic [`ABD_EV_W-1:0]  mask_r;
  logic [`ABD_EV_W-1:0]  mask_nxt;
  logic                  rxif_r;
  logic                  rxif_nxt;
  logic                  rxif_set;
  logic                  ack_r;
  logic                  ack_nxt;
  logic [31:0]           dat_r;
  logic [31:0]           dat_nxt;
  logic                  irq_r;
  logic                  irq_nxt;
  logic                  hold_r;
  logic                  hold_nxt;
  logic                  req;
  logic                  wr_ok;
  logic                  rd_ok;
  logic [7:0]            wd;

  assign rise  = rx_s_r & ~rx_d_r;
  assign fall  = ~rx_s_r & rx_d_r;
  assign req   = WB_CYC_IN & WB_STB_IN;
  assign wr_ok = req & ack_r & WB_WE_IN & WB_SEL_IN[0];
  assign rd_ok = req & ack_r & ~WB_WE_IN;
  assign wd    = WB_DAT_IN[7:0];
  // prescaler wraps at the eighth of the base rate picked by the two bits
  assign tick  = (state_r == S_COUNT) &&
                 (pre_r == div_last(wide_r, hs_r));

  // two-flop synchroniser on the pin, then one stage for edge detection
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      rx_m_r <= 1'b1;
      rx_s_r <= 1'b1;
      rx_d_r <= 1'b1;
    end else begin
      rx_m_r <= RX_IN;
      rx_s_r <= rx_m_r;
      rx_d_r <= rx_s_r;
    end
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    edges_nxt = edges_r;
    pre_nxt   = tick ? 9'h000 : pre_r + `ABD_PRE_ONE;
    start_nxt = start_r;
    wide_nxt  = wide_r;
    hs_nxt    = hs_r;
    wob_nxt   = wob_r;
    mask_nxt  = mask_r;
    sts_set   = '0;
    rxif_set  = 1'b0;
    ack_nxt   = req & ~ack_r;
    dat_nxt   = 32'h0000_0000;
    // register writes; the count pair is frozen to software while busy
    if (wr_ok) begin
      unique case (WB_ADR_IN)
        `ABD_OFF_CTL: begin
          if (state_r == S_IDLE) begin
            wide_nxt  = wd[`ABD_CTL_WIDE];
            hs_nxt    = wd[`ABD_CTL_HS];
            wob_nxt   = wd[`ABD_CTL_WOB];
            start_nxt = wd[`ABD_CTL_START];
            if (wd[`ABD_CTL_START]) begin
              // break first when wake-on-break rides with the start bit
              state_nxt = wd[`ABD_CTL_WOB] ? S_BRK_FALL
                                           : S_START;
            end
          end else if (!wd[`ABD_CTL_START]) begin
            start_nxt = 1'b0;
            state_nxt = S_IDLE;
          end
        end
        `ABD_OFF_LOW: begin
          if (state_r == S_IDLE) begin
            cnt_nxt[7:0] = wd;
          end
        end
        `ABD_OFF_HIGH: begin
          if (state_r == S_IDLE) begin
            cnt_nxt[15:8] = wd;
          end
        end
        `ABD_OFF_MASK: begin
          mask_nxt = wd[`ABD_EV_W-1:0];
        end
        default: begin
        end
      endcase
    end
    unique case (state_r)
      S_IDLE: begin
      end
      S_BRK_FALL: begin
        if (fall) begin
          state_nxt = S_BRK_RISE;
        end
      end
      S_BRK_RISE: begin
        if (rise) begin
          state_nxt = S_START;
          sts_set[`ABD_EV_BRK] = 1'b1;
        end
      end
      S_START: begin
        if (fall) begin
          state_nxt = S_FIRST;
        end
      end
      S_FIRST: begin
        if (rise) begin
          state_nxt = S_COUNT;
          cnt_nxt   = `ABD_CNT_FIRST;
          edges_nxt = `ABD_EDGE_ONE;
          pre_nxt   = 9'h000;
        end
      end
      S_COUNT: begin
        if (tick) begin
          // both bytes step as one word whatever the wide bit says
          cnt_nxt = cnt_r + `ABD_CNT_ONE;
          if (cnt_r == `ABD_CNT_MAX) begin
            sts_set[`ABD_EV_OVF] = 1'b1;
          end
        end
        if (rise) begin
          if (edges_r == `ABD_EDGES_LAST - `ABD_EDGE_ONE) begin
            state_nxt = S_IDLE;
            start_nxt = 1'b0;
            rxif_set  = 1'b1;
            sts_set[`ABD_EV_DONE] = 1'b1;
          end else begin
            edges_nxt = edges_r + `ABD_EDGE_ONE;
          end
        end
      end
    endcase
    if (wr_ok && WB_ADR_IN == `ABD_OFF_STS) begin
      sts_nxt = (sts_r & ~wd[`ABD_EV_W-1:0]) | sts_set;
    end else begin
      sts_nxt = sts_r | sts_set;
    end
    // buffer read clears the flag unless a new completion lands now
    rxif_nxt = (rxif_r & ~(rd_ok && WB_ADR_IN == `ABD_OFF_RXBUF))
               | rxif_set;
    if (req && !ack_r && !WB_WE_IN) begin
      unique case (WB_ADR_IN)
        `ABD_OFF_CTL: begin
          dat_nxt[`ABD_CTL_START] = start_r;
          dat_nxt[`ABD_CTL_WIDE]  = wide_r;
          dat_nxt[`ABD_CTL_HS]    = hs_r;
          dat_nxt[`ABD_CTL_WOB]   = wob_r;
          dat_nxt[`ABD_CTL_BUSY]  = (state_r != S_IDLE);
        end
        `ABD_OFF_LOW: begin
          dat_nxt[7:0] = cnt_r[7:0];
        end
        `ABD_OFF_HIGH: begin
          dat_nxt[7:0] = cnt_r[15:8];
        end
        `ABD_OFF_STS: begin
          dat_nxt[`ABD_EV_W-1:0] = sts_r;
        end
        `ABD_OFF_MASK: begin
          dat_nxt[`ABD_EV_W-1:0] = mask_r;
        end
        default: begin
        end
      endcase
    end
    irq_nxt  = |(sts_nxt & mask_nxt);
    hold_nxt = (state_nxt != S_IDLE);
  end

  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      state_r <= S_IDLE;
      cnt_r   <= `ABD_CNT_RST;
      edges_r <= 3'h0;
      pre_r   <= 9'h000;
      start_r <= 1'b0;
      wide_r  <= 1'b0;
      hs_r    <= 1'b0;
      wob_r   <= 1'b0;
      sts_r   <= '0;
      mask_r  <= '0;
      rxif_r  <= 1'b0;
      ack_r   <= 1'b0;
      dat_r   <= 32'h0000_0000;
      irq_r   <= 1'b0;
      hold_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      edges_r <= edges_nxt;
      pre_r   <= pre_nxt;
      start_r <= start_nxt;
      wide_r  <= wide_nxt;
      hs_r    <= hs_nxt;
      wob_r   <= wob_nxt;
      sts_r   <= sts_nxt;
      mask_r  <= mask_nxt;
      rxif_r  <= rxif_nxt;
      ack_r   <= ack_nxt;
      dat_r   <= dat_nxt;
      irq_r   <= irq_nxt;
      hold_r  <= hold_nxt;
    end
  end

  assign WB_ACK_OUT  = ack_r;
  assign WB_DAT_OUT  = dat_r;
  assign IRQ_OUT     = irq_r;
  assign RXIF_OUT    = rxif_r;
  assign RX_HOLD_OUT = hold_r;

  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (RESET_IN);

  start_launch_a: assert property (
    (state_r == S_IDLE && wr_ok && WB_ADR_IN == `ABD_OFF_CTL
     && wd[`ABD_CTL_START] && !wd[`ABD_CTL_WOB])
    |=> (state_r == S_START && start_r))
    else $error("start bit write did not launch measurement");

  hold_idle_a: assert property (
    (RX_HOLD_OUT == (state_r != S_IDLE)))
    else $error("receiver hold does not follow measurement");

  first_edge_a: assert property (
    (state_r == S_FIRST && rise)
    |=> (state_r == S_COUNT && cnt_r == `ABD_CNT_FIRST))
    else $error("count did not start at one on first rise");

  done_clear_a: assert property (
    (state_r == S_COUNT && rise && edges_r == 3'h4)
    |=> (!start_r && RXIF_OUT && state_r == S_IDLE
         && RX_HOLD_OUT == 1'b0))
    else $error("fifth edge did not finish measurement");

  count_step_a: assert property (
    (state_r == S_COUNT && tick && !rise)
    |=> (cnt_r == $past(cnt_r) + `ABD_CNT_ONE))
    else $error("rate pair did not step as one word");

  fast_rate_a: assert property (
    (tick && wide_r && hs_r)
    |-> ##1 !tick ##31 (tick || state_r != S_COUNT))
    else $error("fast counter clock is not one in 32");

  slow_rate_a: assert property (
    (tick && !wide_r && !hs_r)
    |-> ##[512:512] (tick || state_r != S_COUNT))
    else $error("slow counter clock is not one in 512");

  break_first_a: assert property (
    (state_r == S_IDLE && wr_ok && WB_ADR_IN == `ABD_OFF_CTL
     && wd[`ABD_CTL_START] && wd[`ABD_CTL_WOB])
    |=> (state_r == S_BRK_FALL))
    else $error("wake-on-break did not wait for the break");

  rxif_clear_a: assert property (
    (rd_ok && WB_ADR_IN == `ABD_OFF_RXBUF && !rxif_set)
    |=> !RXIF_OUT)
    else $error("buffer read did not clear receive flag");

  ack_pulse_a: assert property (
    WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack held for more than one cycle");

  irq_level_a: assert property (
    IRQ_OUT == |(sts_r & mask_r))
    else $error("interrupt does not match masked status");

endmodule // uart_auto_baud_detect

// ==== sim/sync_sender.sv ====
// far-end model: a serial sender of one 55h sync character, optionally
// preceded by a break; assumes go_in is a one-clock pulse with settings held
`timescale 1ns/1ps

module sync_sender (
  input  wire logic        clk_in,     // bench clock
  input  wire logic        go_in,      // start one transmission
  input  wire logic        brk_in,     // send a break first
  input  wire logic [15:0] bit_len_in, // clocks per bit
  output logic             rx_out      // serial line, idle high
);
  // start bit, 55h lsb first, stop bit: five rising edges
  localparam logic [9:0] FRAME = {1'b1, 8'h55, 1'b0};

  initial rx_out = 1'b1;

  always @(posedge clk_in) begin
    if (go_in) begin
      if (brk_in) begin
        rx_out <= 1'b0;
        repeat (13 * bit_len_in) @(posedge clk_in);
        rx_out <= 1'b1;
        repeat (bit_len_in) @(posedge clk_in);
      end
      // bit time chosen by the bench inside the measurable range
      for (int i = 0; i < 10; i++) begin
        rx_out <= FRAME[i];
        repeat (bit_len_in) @(posedge clk_in);
      end
      rx_out <= 1'b1;
    end
  end
endmodule // sync_sender

// ==== sim/testbench.sv ====
// top-level bench: register access and 55h sync measurements
// assumes the auto-baud block, the sync_sender model and one 40 MHz clock
`timescale 1ns/1ps
`include "abd_map.svh"

module testbench;
  import abd_pkg::*;
  logic        mclk    = 1'b0;
  logic        rst     = 1'b1;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic [7:0]  adr     = 8'h00;
  logic [3:0]  sel     = 4'h0;
  logic [31:0] wdat    = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        rx;
  logic        irq;
  logic        rxif;
  logic        hold;
  logic        go      = 1'b0;
  logic        brk     = 1'b0;
  logic        irq_en  = 1'b0;
  logic [15:0] bit_len = 16'h0001;
  int          errors  = 0;
  int          checks  = 0;
  int          cycles  = 0;
  logic [7:0]  offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c};

  uart_auto_baud_detect dut_u (
    .MCLK_IN(mclk), .RESET_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .RX_IN(rx), .IRQ_OUT(irq),
    .RXIF_OUT(rxif), .RX_HOLD_OUT(hold));

  sync_sender sender_u (.clk_in(mclk), .go_in(go), .brk_in(brk),
    .bit_len_in(bit_len), .rx_out(rx));

  always #12.5 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb_rw(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    do @(posedge mclk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb_rw(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic measure(input logic [1:0] m, input logic [15:0] b,
                         input logic wob);
    logic [31:0] q;
    logic [15:0] e;
    int          n;
    n = (m == 2'b00) ? 512 : (m == 2'b11) ? 32 : 128;
    e = 16'h0001 + 16'((8 * b) / n);
    wb_rw(1'b1, `ABD_OFF_CTL, {28'h0, wob, m[0], m[1], 1'b1}, q);
    bit_len <= b; brk <= wob; go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    @(negedge mclk);
    chk(32'(hold), 32'h1);
    for (int w = 0; w < 30000 && rxif !== 1'b1; w++) @(posedge mclk);
    @(negedge mclk);
    chk(32'(rxif), 32'h1);
    chk(32'(hold), 32'h0);
    chk(32'(irq), 32'(irq_en));
    rchk(`ABD_OFF_CTL, {28'h0, wob, m[0], m[1], 1'b0});
    rchk(`ABD_OFF_LOW, {24'h0, e[7:0]});
    rchk(`ABD_OFF_HIGH, {24'h0, e[15:8]});
    rchk(`ABD_OFF_STS, {29'h0, wob, 1'b0, 1'b1});
    wb_rw(1'b0, `ABD_OFF_RXBUF, 32'h0, q);
    wb_rw(1'b1, `ABD_OFF_STS, 32'h7, q);
    rchk(`ABD_OFF_STS, 32'h0);
    @(negedge mclk);
    chk(32'(rxif), 32'h0);
    chk(32'(irq), 32'h0);
    // let the sender finish its stop bit so the next go pulse is seen
    repeat (2 * b) @(posedge mclk);
    $display("measure mode %b wob %b done", m, wob);
  endtask

  initial begin
    logic [31:0] q;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    foreach (offs[i]) rchk(offs[i], 32'h0);
    $display("reset values done");
    measure(2'b00, 16'd224, 1'b0);
    wb_rw(1'b1, `ABD_OFF_MASK, 32'h1, q);
    irq_en = 1'b1;
    measure(2'b01, 16'd168, 1'b0);
    measure(2'b10, 16'd168, 1'b0);
    measure(2'b11, 16'd82, 1'b0);
    measure(2'b11, 16'd82, 1'b1);
    wrap_up();
  end
endmodule // testbench
